/* File: rtl/tpp_pkg.sv */
// Purpose: Shared constants for the trajectory parameter block
// Assumes: Dictionary index and sub-index addressing, 32-bit data
// Notes: Velocities are signed 0.1 counts/s, accelerations 10 counts/s^2
package tpp_pkg;
    // Dictionary indices of the parameter set
    localparam logic [15:0] TPP_IDX_MAX_SPEED = 16'h6080;
    localparam logic [15:0] TPP_IDX_PROF_VEL = 16'h6081;
    localparam logic [15:0] TPP_IDX_END_VEL = 16'h6082;
    localparam logic [15:0] TPP_IDX_PROF_ACC = 16'h6083;
    localparam logic [15:0] TPP_IDX_PROF_DEC = 16'h6084;
    localparam logic [15:0] TPP_IDX_QS_DEC = 16'h6085;
    localparam logic [15:0] TPP_IDX_PROF_TYPE = 16'h6086;
    localparam logic [15:0] TPP_IDX_JERK_SET = 16'h60a4;
    localparam logic [15:0] TPP_IDX_VL_ACC = 16'h60c5;
    localparam logic [15:0] TPP_IDX_VL_DEC = 16'h60c6;
    // Sub-indices of the jerk array
    localparam logic [7:0] TPP_SUB_COUNT = 8'h00;
    localparam logic [7:0] TPP_SUB_JERK1 = 8'h01;
    localparam logic [31:0] TPP_JERK_COUNT = 32'h0000_0001;
    // Motion profile type codes
    localparam logic [15:0] TPP_TYPE_TRAP = 16'h0000;
    localparam logic [15:0] TPP_TYPE_SCURVE = 16'h0003;
    localparam logic [15:0] TPP_TYPE_VEL = 16'hffff;
    // Reset values
    localparam logic [31:0] TPP_RST_WORD = 32'h0000_0000;
    localparam logic [15:0] TPP_RST_TYPE = 16'h0000;
    // Loop widths
    localparam int TPP_GAIN_W = 16;
    localparam int TPP_SUM_W = 40;
    localparam int TPP_P_W = 50;
    localparam int TPP_I_W = 57;
endpackage : tpp_pkg

/* File: rtl/tpp_trajectory_params.sv */
// Purpose: Trajectory parameter set, profile ramp, velocity-loop limiter and PI terms
// Assumes: Dictionary strobes and servo tick come from logic on clk
// Notes: Position profiling itself lives outside; it signals the final leg
// How it works
// - Velocity mode ramps to target velocity at the unbuffered profile acc/dec
// - Position mode parameters apply on start edge
// - Buffered profile velocity is the cruise speed
// - End velocity honoured only for trapezoid
// - Profile acceleration; S-curve also decelerates with it
// - Profile deceleration for trapezoid and velocity profiles
// - Quick stop ramps velocity down to zero
// - Quick-stop deceleration is never buffered
// - Zero quick-stop deceleration stops at once
// - Type codes 0, 3, -1, buffered
// - Unsupported type codes rejected, old kept
// - Jerk array: count, then first jerk
// - Rising speed limited by max acceleration
// - Falling speed limited by max deceleration
// - Error times proportional gain
// - Accumulated error times integral gain
`timescale 1ns/100ps
module tpp_trajectory_params
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic od_wr,
    input wire logic od_rd,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    input wire logic [31:0] od_wdata,
    output logic [31:0] od_rdata,
    output logic od_ack,
    output logic od_err,
    input wire logic mode_velocity,
    input wire logic ctrl_start,
    input wire logic final_leg,
    input wire logic quick_stop,
    input wire logic servo_tick,
    input wire logic signed [31:0] target_velocity,
    input wire logic signed [31:0] actual_velocity,
    input wire logic [tpp_pkg::TPP_GAIN_W-1:0] velocity_proportional_gain,
    input wire logic [tpp_pkg::TPP_GAIN_W-1:0] velocity_integral_gain,
    output logic signed [31:0] traj_velocity,
    output logic signed [31:0] vloop_command,
    output logic [15:0] active_profile_type,
    output logic signed [tpp_pkg::TPP_P_W-1:0] vloop_p_term,
    output logic signed [tpp_pkg::TPP_I_W-1:0] vloop_i_term
);
    import tpp_pkg::*;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] max_speed;        // Stored only, read back
        logic [31:0] prof_vel;         // Written, awaiting start
        logic [31:0] end_vel;
        logic [31:0] prof_acc;
        logic [31:0] prof_dec;
        logic [31:0] qs_dec;           // Live, no shadow copy
        logic [15:0] prof_type;
        logic [31:0] jerk1;
        logic [31:0] vl_acc;
        logic [31:0] vl_dec;
        logic [31:0] a_vel;            // Applied copies
        logic [31:0] a_end;
        logic [31:0] a_acc;
        logic [31:0] a_dec;
        logic [15:0] a_type;
        logic start_prev;              // Start bit history for edge
        logic signed [31:0] traj_vel;  // Generator velocity
        logic signed [31:0] vcmd;      // Rate-limited loop command
        logic signed [TPP_SUM_W-1:0] err_sum;
        logic signed [TPP_P_W-1:0] p_term;
        logic signed [TPP_I_W-1:0] i_term;
        logic [31:0] rdata;
        logic ack;
        logic err;
    } tpp_state_s;

    tpp_state_s st_r;
    tpp_state_s st_nxt;

    // Step cur toward tgt; away from zero uses up_lim, toward zero dn_lim
    function automatic logic signed [31:0] tpp_ramp(
        input logic signed [31:0] cur,
        input logic signed [31:0] tgt,
        input logic [31:0] up_lim,
        input logic [31:0] dn_lim
    );
        logic signed [33:0] d;
        logic signed [33:0] mag;
        logic signed [33:0] r;
        logic up;
        logic [31:0] lim;
        d = {{2{tgt[31]}}, tgt} - {{2{cur[31]}}, cur};
        up = ((d > 0) && !cur[31]) || ((d < 0) && (cur[31] || (cur == 32'sh0)));
        lim = up ? up_lim : dn_lim;
        mag = (d < 0) ? -d : d;
        r = {{2{cur[31]}}, cur};
        if (mag <= $signed({2'b00, lim}))
        begin
            r = {{2{tgt[31]}}, tgt};
        end
        else if (d > 0)
        begin
            r = r + $signed({2'b00, lim});
        end
        else
        begin
            r = r - $signed({2'b00, lim});
        end
        return r[31:0];
    endfunction : tpp_ramp

    // Unsigned profile word to signed velocity, clamped at the top
    function automatic logic signed [31:0] tpp_to_vel(input logic [31:0] u);
        return u[31] ? 32'sh7fff_ffff : $signed(u);
    endfunction : tpp_to_vel

    // Supported motion profile type code
    function automatic logic tpp_type_ok(input logic [15:0] t);
        return (t == TPP_TYPE_TRAP) || (t == TPP_TYPE_SCURVE) || (t == TPP_TYPE_VEL);
    endfunction : tpp_type_ok

    logic start_edge;
    logic signed [31:0] gen_target;
    logic [31:0] gen_up;
    logic [31:0] gen_dn;
    logic signed [32:0] vel_err;

    // Start command edge and generator target selection
    always_comb
    begin
        start_edge = ctrl_start && !st_r.start_prev;
        gen_up = st_r.a_acc;
        gen_dn = st_r.a_dec;
        if (mode_velocity)
        begin
            // No buffer: a new target acts at the next tick
            gen_target = target_velocity;
            gen_up = st_r.prof_acc;
            gen_dn = st_r.prof_dec;
        end
        else if (st_r.a_type == TPP_TYPE_SCURVE)
        begin
            // S-curve ends with zero speed and the acceleration value
            gen_target = final_leg ? 32'sh0 : tpp_to_vel(st_r.a_vel);
            gen_dn = st_r.a_acc;
        end
        else if (st_r.a_type == TPP_TYPE_TRAP)
        begin
            gen_target = final_leg ? tpp_to_vel(st_r.a_end) : tpp_to_vel(st_r.a_vel);
        end
        else
        begin
            // Special velocity profile inside position mode
            gen_target = tpp_to_vel(st_r.a_vel);
        end
        vel_err = {st_r.vcmd[31], st_r.vcmd} - {actual_velocity[31], actual_velocity};
    end

    // Next state: dictionary access, buffering and servo-cycle update
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = od_wr || od_rd;
        st_nxt.err = 1'b0;
        st_nxt.start_prev = ctrl_start;
        // Dictionary writes land in the pending set
        if (od_wr)
        begin
            unique case (od_index)
                TPP_IDX_MAX_SPEED: st_nxt.max_speed = od_wdata;
                TPP_IDX_PROF_VEL: st_nxt.prof_vel = od_wdata;
                TPP_IDX_END_VEL: st_nxt.end_vel = od_wdata;
                TPP_IDX_PROF_ACC: st_nxt.prof_acc = od_wdata;
                TPP_IDX_PROF_DEC: st_nxt.prof_dec = od_wdata;
                TPP_IDX_QS_DEC: st_nxt.qs_dec = od_wdata;
                TPP_IDX_PROF_TYPE:
                begin
                    if (tpp_type_ok(od_wdata[15:0]))
                    begin
                        st_nxt.prof_type = od_wdata[15:0];
                    end
                    else
                    begin
                        st_nxt.err = 1'b1;
                    end
                end
                TPP_IDX_JERK_SET:
                begin
                    // Element count is fixed, so sub-index 0 refuses writes
                    if (od_subindex == TPP_SUB_JERK1)
                    begin
                        st_nxt.jerk1 = od_wdata;
                    end
                    else
                    begin
                        st_nxt.err = 1'b1;
                    end
                end
                TPP_IDX_VL_ACC: st_nxt.vl_acc = od_wdata;
                TPP_IDX_VL_DEC: st_nxt.vl_dec = od_wdata;
                default: st_nxt.err = 1'b1;
            endcase
        end
        // Dictionary reads show the stored values
        if (od_rd)
        begin
            st_nxt.rdata = TPP_RST_WORD;
            unique case (od_index)
                TPP_IDX_MAX_SPEED: st_nxt.rdata = st_r.max_speed;
                TPP_IDX_PROF_VEL: st_nxt.rdata = st_r.prof_vel;
                TPP_IDX_END_VEL: st_nxt.rdata = st_r.end_vel;
                TPP_IDX_PROF_ACC: st_nxt.rdata = st_r.prof_acc;
                TPP_IDX_PROF_DEC: st_nxt.rdata = st_r.prof_dec;
                TPP_IDX_QS_DEC: st_nxt.rdata = st_r.qs_dec;
                TPP_IDX_PROF_TYPE: st_nxt.rdata = {{16{st_r.prof_type[15]}}, st_r.prof_type};
                TPP_IDX_JERK_SET:
                begin
                    if (od_subindex == TPP_SUB_COUNT)
                    begin
                        st_nxt.rdata = TPP_JERK_COUNT;
                    end
                    else if (od_subindex == TPP_SUB_JERK1)
                    begin
                        st_nxt.rdata = st_r.jerk1;
                    end
                    else
                    begin
                        st_nxt.err = 1'b1;
                    end
                end
                TPP_IDX_VL_ACC: st_nxt.rdata = st_r.vl_acc;
                TPP_IDX_VL_DEC: st_nxt.rdata = st_r.vl_dec;
                default: st_nxt.err = 1'b1;
            endcase
        end
        // Start edge copies the pending set; a same-cycle write waits
        if (start_edge)
        begin
            st_nxt.a_vel = st_r.prof_vel;
            st_nxt.a_end = st_r.end_vel;
            st_nxt.a_acc = st_r.prof_acc;
            st_nxt.a_dec = st_r.prof_dec;
            st_nxt.a_type = st_r.prof_type;
        end
        // One servo cycle: generator, limiter, PI, all from sampled values
        if (servo_tick)
        begin
            if (quick_stop)
            begin
                // Live value, so a rewrite mid-abort acts on the next tick
                if (st_r.qs_dec == TPP_RST_WORD)
                begin
                    st_nxt.traj_vel = 32'sh0;
                end
                else
                begin
                    st_nxt.traj_vel = tpp_ramp(st_r.traj_vel, 32'sh0, st_r.qs_dec, st_r.qs_dec);
                end
            end
            else
            begin
                st_nxt.traj_vel = tpp_ramp(st_r.traj_vel, gen_target, gen_up, gen_dn);
            end
            // A zero limit freezes the command; software must set both
            st_nxt.vcmd = tpp_ramp(st_r.vcmd, st_r.traj_vel, st_r.vl_acc, st_r.vl_dec);
            st_nxt.err_sum = st_r.err_sum + TPP_SUM_W'(vel_err);
            st_nxt.p_term = TPP_P_W'(vel_err * $signed({1'b0, velocity_proportional_gain}));
            st_nxt.i_term = TPP_I_W'(st_r.err_sum * $signed({1'b0, velocity_integral_gain}));
        end
    end

    // State register; parameters clear to zero, type to trapezoid
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.prof_type <= TPP_RST_TYPE;
            st_r.a_type <= TPP_RST_TYPE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign od_rdata = st_r.rdata;
    assign od_ack = st_r.ack;
    assign od_err = st_r.err;
    assign traj_velocity = st_r.traj_vel;
    assign vloop_command = st_r.vcmd;
    assign active_profile_type = st_r.a_type;
    assign vloop_p_term = st_r.p_term;
    assign vloop_i_term = st_r.i_term;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_start_rise;
        !ctrl_start ##1 ctrl_start;
    endsequence

    a_buffer_on_start: assert property (s_start_rise |=> active_profile_type == $past(st_r.prof_type))
        else $error("applied type not taken at start edge");
    a_buffer_held: assert property (!(ctrl_start && !st_r.start_prev) |=> $stable(st_r.a_vel))
        else $error("applied velocity moved without start edge");
    // From standstill a reachable target lands in one tick, either sign
    a_vel_passthru: assert property (
        servo_tick && mode_velocity && !quick_stop && traj_velocity == 32'sh0 && !st_r.prof_acc[31]
        && target_velocity != 32'sh8000_0000
        && (target_velocity < 32'sh0 ? -target_velocity : target_velocity) <= $signed(st_r.prof_acc)
        |=> traj_velocity == $past(target_velocity))
        else $error("velocity mode target not forwarded");
    a_qs_zero_stop: assert property (
        servo_tick && quick_stop && st_r.qs_dec == 32'h0 |=> traj_velocity == 32'sh0)
        else $error("zero quick-stop deceleration did not stop");
    a_qs_toward_zero: assert property (
        servo_tick && quick_stop && traj_velocity > 32'sh0
        |=> traj_velocity < $past(traj_velocity) && traj_velocity >= 32'sh0)
        else $error("quick stop not ramping down");
    a_type_reject: assert property (
        od_wr && od_index == TPP_IDX_PROF_TYPE && !tpp_type_ok(od_wdata[15:0])
        |=> od_err && $stable(st_r.prof_type))
        else $error("bad profile type accepted");
    a_jerk_count: assert property (
        od_rd && od_index == TPP_IDX_JERK_SET && od_subindex == TPP_SUB_COUNT
        |=> od_ack && od_rdata == TPP_JERK_COUNT)
        else $error("jerk count wrong");
    a_tick_only: assert property (!servo_tick |=> $stable(vloop_command) && $stable(st_r.err_sum))
        else $error("loop changed without servo tick");
    a_accel_limit: assert property (
        servo_tick && vloop_command >= 32'sh0 && traj_velocity > vloop_command
        && st_r.vl_acc < 32'h4000_0000
        |=> (vloop_command - $past(vloop_command)) <= $signed($past(st_r.vl_acc)))
        else $error("rising speed exceeded max acceleration");
    a_decel_limit: assert property (
        servo_tick && vloop_command > 32'sh0 && traj_velocity < vloop_command
        && traj_velocity >= 32'sh0 && st_r.vl_dec < 32'h4000_0000
        |=> ($past(vloop_command) - vloop_command) <= $signed($past(st_r.vl_dec)))
        else $error("falling speed exceeded max deceleration");
    a_p_term: assert property (
        servo_tick ##1 1'b1 |-> vloop_p_term == TPP_P_W'($past(vel_err)
        * $signed({1'b0, $past(velocity_proportional_gain)})))
        else $error("proportional term mismatch");
endmodule : tpp_trajectory_params

/* File: tb/tpp_master_model.sv */
// Purpose: Network master model issuing dictionary accesses and the start bit
// Assumes: One access in flight; answer sampled just after the edge that follows the strobe
// Notes: Released index, sub-index and data lines show the inverse of the last value and strobes drop to 0, so stale data never looks valid
`timescale 1ns/100ps
module tpp_master_model (
    input wire logic clk,
    output logic od_wr,
    output logic od_rd,
    output logic [15:0] od_index,
    output logic [7:0] od_subindex,
    output logic [31:0] od_wdata,
    input wire logic [31:0] od_rdata,
    input wire logic od_ack,
    input wire logic od_err,
    output logic ctrl_start
);
    // Idle levels at time zero
    initial
    begin
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_index = 16'h0000;
        od_subindex = 8'h00;
        od_wdata = 32'h0000_0000;
        ctrl_start = 1'b0;
    end

    // One access: strobe held for one edge, answer taken after the next
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] data, output logic [31:0] rdata, output logic ack, output logic err);
        @(posedge clk);
        od_wr <= wr;
        od_rd <= ~wr;
        od_index <= idx;
        od_subindex <= sub;
        od_wdata <= data;
        @(posedge clk);
        od_wr <= 1'b0;
        od_rd <= 1'b0;
        od_index <= ~idx;
        od_subindex <= ~sub;
        od_wdata <= ~data;
        #1;
        ack = od_ack;
        err = od_err;
        rdata = od_rdata;
    endtask : access

    // Start bit goes 0 then 1; buffered set applies on that edge
    task automatic start_move();
        @(posedge clk);
        ctrl_start <= 1'b0;
        @(posedge clk);
        ctrl_start <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : start_move
endmodule : tpp_master_model

/* File: tb/tpp_trajectory_params_test.sv */
// Purpose: Self-checking bench for the trajectory parameter block
// Assumes: Dictionary traffic comes from the master model; servo ticks from here
// Notes: Ramp state carries across phases, so the phase order matters
`timescale 1ns/100ps
module tpp_trajectory_params_test;
    import tpp_pkg::*;
    logic clk, rst_n, od_wr, od_rd, od_ack, od_err, ctrl_start;
    logic mode_velocity, final_leg, quick_stop, servo_tick;
    logic [15:0] od_index, active_profile_type;
    logic [7:0] od_subindex;
    logic [31:0] od_wdata, od_rdata;
    logic signed [31:0] target_velocity, actual_velocity, traj_velocity, vloop_command;
    logic [TPP_GAIN_W-1:0] velocity_proportional_gain, velocity_integral_gain;
    logic signed [TPP_P_W-1:0] vloop_p_term;
    logic signed [TPP_I_W-1:0] vloop_i_term, i_first;
    int errors, checks_done, cycles;
    // Every mapped index; jerk checked through its first value
    logic [15:0] regs [10] = '{TPP_IDX_MAX_SPEED, TPP_IDX_PROF_VEL, TPP_IDX_END_VEL, TPP_IDX_PROF_ACC,
        TPP_IDX_PROF_DEC, TPP_IDX_QS_DEC, TPP_IDX_PROF_TYPE, TPP_IDX_JERK_SET, TPP_IDX_VL_ACC, TPP_IDX_VL_DEC};

    tpp_trajectory_params DUT (.clk(clk), .rst_n(rst_n), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
        .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
        .mode_velocity(mode_velocity), .ctrl_start(ctrl_start), .final_leg(final_leg), .quick_stop(quick_stop),
        .servo_tick(servo_tick), .target_velocity(target_velocity), .actual_velocity(actual_velocity),
        .velocity_proportional_gain(velocity_proportional_gain), .velocity_integral_gain(velocity_integral_gain),
        .traj_velocity(traj_velocity), .vloop_command(vloop_command), .active_profile_type(active_profile_type),
        .vloop_p_term(vloop_p_term), .vloop_i_term(vloop_i_term));
    tpp_master_model MST (.clk(clk), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err), .ctrl_start(ctrl_start));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end

    // Compare and count
    task automatic chk(input string nm, input logic signed [63:0] e, input logic signed [63:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk

    // Write, check answer, read back when accepted
    task automatic wchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v, input logic bad);
        logic [31:0] d;
        logic a, e;
        MST.access(1'b1, idx, sub, v, d, a, e);
        chk("write answer", {bad, 1'b1, bad}, {e, a, e});
        if (!bad)
            rchk(idx, sub, v, 1'b0);
    endtask : wchk

    // Read and check answer and data
    task automatic rchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] v, input logic bad);
        logic [31:0] d;
        logic a, e;
        MST.access(1'b0, idx, sub, 32'h0000_0000, d, a, e);
        chk("read answer", {bad, 1'b1}, {e, a});
        if (!bad)
            chk("read data", v, d);
    endtask : rchk

    // Servo ticks, outputs settled on return
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            servo_tick <= 1'b1;
            @(posedge clk);
            servo_tick <= 1'b0;
            #1;
        end
    endtask : tick

    // Verdict and end of run
    task automatic conclude();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        {errors, checks_done, cycles} = '0;
        {rst_n, mode_velocity, final_leg, quick_stop, servo_tick} = '0;
        target_velocity = 32'sh0000_0000;
        actual_velocity = 32'sh0000_0000;
        velocity_proportional_gain = 16'h0003;
        velocity_integral_gain = 16'h0002;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (regs[i]) rchk(regs[i], (regs[i] == TPP_IDX_JERK_SET) ? 8'h01 : 8'h00, 32'h0, 1'b0);
        rchk(TPP_IDX_JERK_SET, TPP_SUB_COUNT, TPP_JERK_COUNT, 1'b0);
        rchk(16'h6087, 8'h00, 32'h0, 1'b1);
        rchk(TPP_IDX_JERK_SET, 8'h02, 32'h0, 1'b1);
        wchk(TPP_IDX_JERK_SET, TPP_SUB_COUNT, 32'h5, 1'b1);
        wchk(TPP_IDX_JERK_SET, TPP_SUB_JERK1, 32'd77, 1'b0);
        wchk(TPP_IDX_MAX_SPEED, 8'h00, 32'd12345, 1'b0);
        wchk(TPP_IDX_VL_ACC, 8'h00, 32'd200, 1'b0);
        wchk(TPP_IDX_VL_DEC, 8'h00, 32'd50, 1'b0);
        wchk(TPP_IDX_PROF_VEL, 8'h00, 32'd500, 1'b0);
        wchk(TPP_IDX_PROF_ACC, 8'h00, 32'd100, 1'b0);
        wchk(TPP_IDX_PROF_DEC, 8'h00, 32'd50, 1'b0);
        wchk(TPP_IDX_END_VEL, 8'h00, 32'd200, 1'b0);
        wchk(TPP_IDX_QS_DEC, 8'h00, 32'd100, 1'b0);
        tick(1);
        chk("traj before start", 0, traj_velocity);
        MST.start_move();
        for (int k = 1; k <= 6; k++)
        begin
            tick(1);
            chk("traj cruise", (k < 5) ? 100 * k : 500, traj_velocity);
        end
        @(posedge clk) final_leg <= 1'b1;
        for (int k = 1; k <= 7; k++)
        begin
            tick(1);
            chk("traj final", (k < 6) ? 500 - 50 * k : 200, traj_velocity);
        end
        wchk(TPP_IDX_PROF_DEC, 8'h00, 32'd10, 1'b0);
        wchk(TPP_IDX_PROF_TYPE, 8'h00, 32'd3, 1'b0);
        chk("type held", 0, active_profile_type);
        MST.start_move();
        chk("type applied", 3, active_profile_type);
        tick(1);
        chk("scurve end", 100, traj_velocity);
        wchk(TPP_IDX_PROF_TYPE, 8'h00, 32'd5, 1'b1);
        rchk(TPP_IDX_PROF_TYPE, 8'h00, 32'd3, 1'b0);
        wchk(TPP_IDX_PROF_TYPE, 8'h00, 32'hffff_ffff, 1'b0);
        tick(1);
        chk("scurve zero", 0, traj_velocity);
        @(posedge clk);
        mode_velocity <= 1'b1;
        final_leg <= 1'b0;
        target_velocity <= 32'sd1000;
        for (int k = 1; k <= 6; k++)
        begin
            tick(1);
            chk("traj velocity mode", 100 * k, traj_velocity);
        end
        @(posedge clk) quick_stop <= 1'b1;
        tick(1);
        chk("quick stop", 500, traj_velocity);
        wchk(TPP_IDX_QS_DEC, 8'h00, 32'd250, 1'b0);
        tick(1);
        chk("quick stop live", 250, traj_velocity);
        wchk(TPP_IDX_QS_DEC, 8'h00, 32'd0, 1'b0);
        tick(1);
        chk("quick stop zero", 0, traj_velocity);
        @(posedge clk);
        quick_stop <= 1'b0;
        target_velocity <= 32'sd0;
        wchk(TPP_IDX_VL_DEC, 8'h00, 32'd1000, 1'b0);
        tick(3);
        wchk(TPP_IDX_VL_DEC, 8'h00, 32'd50, 1'b0);
        wchk(TPP_IDX_PROF_ACC, 8'h00, 32'd1000, 1'b0);
        @(posedge clk) target_velocity <= -32'sd1000;
        tick(1);
        chk("traj negative", -1000, traj_velocity);
        for (int k = 1; k <= 3; k++)
        begin
            tick(1);
            chk("vloop rise", -200 * k, vloop_command);
        end
        wchk(TPP_IDX_PROF_DEC, 8'h00, 32'd1000, 1'b0);
        @(posedge clk) target_velocity <= 32'sd0;
        for (int k = 0; k < 3; k++)
        begin
            tick(1);
            chk("vloop turn", (k == 0) ? -800 : -800 + 50 * k, vloop_command);
        end
        tick(14);
        chk("vloop settled", 0, vloop_command);
        @(posedge clk) actual_velocity <= -32'sd10;
        tick(3);
        chk("p term", 30, vloop_p_term);
        i_first = vloop_i_term;
        tick(1);
        chk("i term step", 20, vloop_i_term - i_first);
        // Special velocity profile ignores the final leg, unlike trapezoid and S-curve
        @(posedge clk);
        mode_velocity <= 1'b0;
        final_leg <= 1'b1;
        MST.start_move();
        chk("type special", 16'hffff, active_profile_type);
        tick(1);
        chk("special velocity", 500, traj_velocity);
        conclude();
    end
endmodule : tpp_trajectory_params_test
